// ===== core/elcam_monitor.sv
// line code alarm monitor top: rail synchronisers, registers, interrupt
// assumes rails are asynchronous pins, one bit period per clock cycle

module elcam_monitor
    import elcam_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic RX_POSITIVE_RAIL_I,
    input wire logic RX_NEGATIVE_RAIL_I,
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [DATA_W-1:0] REG_RDATA_O,
    output logic DECODED_DATA_O,
    output logic INTERRUPT_OUT_N_O
);

    // ***************************************************************
    // helpers
    // ***************************************************************
    function automatic logic bus_hit(
        input logic strobe,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        return strobe && (addr == target);
    endfunction

    function automatic logic [7:0] absent_threshold(input elcam_cfg_t c);
        logic [7:0] t;
        t = c.plain ? THR_PLAIN : THR_SUBST;
        case (c.thr_sel)
            2'h1: t = THR_SEL1;
            2'h2: t = THR_SEL2;
            2'h3: t = THR_SEL3;
            default: t = c.plain ? THR_PLAIN : THR_SUBST;
        endcase
        return t; // R14
    endfunction

    // ***************************************************************
    // declarations
    // ***************************************************************
    logic [1:0] pos_sync_r;
    logic [1:0] neg_sync_r;
    elcam_cfg_t cfg_r;
    logic [3:0] en_r;
    logic alt_en_r;
    logic [3:0] pend_r;
    logic [3:0] pend_set;
    logic [3:0] pend_clr;
    logic alt_pend_r;
    logic absent_r;
    logic absent_nxt;
    elcam_alt_state_t alt_state_r;
    elcam_alt_state_t alt_nxt;
    logic alt_on;
    logic [7:0] quiet_r;
    logic [7:0] thr;
    logic [7:0] space_run;
    elcam_evt_t ev;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_r;
    logic data_r;
    logic irq_n_r;
    logic wr_cfg;
    logic wr_en;
    logic wr_stat;
    logic wr_alt;
    logic rd_stat;
    logic rd_alt;

    assign wr_cfg = bus_hit(REG_WR_I, REG_ADDR_I, CFG_ADDR);
    assign wr_en = bus_hit(REG_WR_I, REG_ADDR_I, EN_ADDR);
    assign wr_stat = bus_hit(REG_WR_I, REG_ADDR_I, STAT_ADDR);
    assign wr_alt = bus_hit(REG_WR_I, REG_ADDR_I, ALT_ADDR);
    assign rd_stat = bus_hit(REG_RD_I, REG_ADDR_I, STAT_ADDR);
    assign rd_alt = bus_hit(REG_RD_I, REG_ADDR_I, ALT_ADDR);

    // ***************************************************************
    // rail synchronisers
    // ***************************************************************
    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            pos_sync_r <= 2'h0;
            neg_sync_r <= 2'h0;
        end
        else
        begin
            pos_sync_r <= {pos_sync_r[0], RX_POSITIVE_RAIL_I};
            neg_sync_r <= {neg_sync_r[0], RX_NEGATIVE_RAIL_I};
        end
    end

    elcam_decode u_decode (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .pos_i(pos_sync_r[1]),
        .neg_i(neg_sync_r[1]),
        .cfg_i(cfg_r),
        .evt_o(ev),
        .space_run_o(space_run)
    );

    // ***************************************************************
    // control registers
    // ***************************************************************
    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            cfg_r <= CFG_RST;
        end
        else if (wr_cfg)
        begin
            cfg_r.plain <= REG_WDATA_I[CFG_PLAIN_BIT];
            cfg_r.thr_sel <= {REG_WDATA_I[CFG_SEL_HI_BIT],
                              REG_WDATA_I[CFG_SEL_LO_BIT]};
            cfg_r.pol_only <= REG_WDATA_I[CFG_POL_BIT];
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            en_r <= EN_RST; // R2
            alt_en_r <= 1'b0;
        end
        else
        begin
            if (wr_en)
            begin
                en_r <= REG_WDATA_I[EV_HI_BIT:EV_LO_BIT];
            end
            if (wr_alt)
            begin
                alt_en_r <= REG_WDATA_I[ALT_EN_BIT];
            end
        end
    end

    // ***************************************************************
    // signal absence
    // ***************************************************************
    assign thr = absent_threshold(cfg_r);
    assign absent_nxt = (space_run > thr) | (absent_r & ~ev.mark); // R10

    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            absent_r <= 1'b0;
        end
        else
        begin
            absent_r <= absent_nxt;
        end
    end

    // ***************************************************************
    // strict signal absence
    // ***************************************************************
    // every period from the fourth zero of a run of zeros on restarts the wait,
    // so a dead line can never time the alarm out
    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            quiet_r <= RUN_RST;
        end
        else if (ev.z4 || space_run >= Z4_LEN)
        begin
            quiet_r <= RUN_RST;
        end
        else if (quiet_r != QUIET_PERIODS)
        begin
            quiet_r <= quiet_r + 8'h01;
        end
    end

    always_comb
    begin
        alt_nxt = alt_state_r;
        case (alt_state_r)
            ALT_CLEAR:
            begin
                if (space_run > thr)
                begin
                    alt_nxt = ALT_DECLARED; // R13
                end
            end
            ALT_DECLARED:
            begin
                if (quiet_r == QUIET_PERIODS)
                begin
                    alt_nxt = ALT_CLEAR; // R13
                end
            end
            default: alt_nxt = ALT_CLEAR;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            alt_state_r <= ALT_CLEAR;
        end
        else
        begin
            alt_state_r <= alt_nxt;
        end
    end

    assign alt_on = (alt_state_r == ALT_DECLARED);

    // ***************************************************************
    // pending bits; a set in the clearing cycle survives
    // ***************************************************************
    assign pend_set = {ev.viol, absent_nxt != absent_r, ev.sig, ev.z4}; // R7
    assign pend_clr = rd_stat ? 4'hF :
                      wr_stat ? REG_WDATA_I[EV_HI_BIT:EV_LO_BIT] : 4'h0;

    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            pend_r <= PEND_RST;
        end
        else
        begin
            pend_r <= pend_set | (pend_r & ~pend_clr); // R3
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            alt_pend_r <= 1'b0;
        end
        else if (alt_nxt != alt_state_r)
        begin
            alt_pend_r <= 1'b1; // R12
        end
        else if (rd_alt || (wr_alt && REG_WDATA_I[ALT_PEND_BIT]))
        begin
            alt_pend_r <= 1'b0; // R12
        end
    end

    // ***************************************************************
    // interrupt
    // ***************************************************************
    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            irq_n_r <= 1'b1;
        end
        else
        begin
            // R1 R11 R16
            irq_n_r <= ~(|(pend_r & en_r) | (alt_pend_r & alt_en_r));
        end
    end

    // ***************************************************************
    // read path
    // ***************************************************************
    always_comb
    begin
        rd_mux = '0;
        case (REG_ADDR_I)
            CFG_ADDR:
            begin
                rd_mux[CFG_PLAIN_BIT] = cfg_r.plain;
                rd_mux[CFG_SEL_HI_BIT] = cfg_r.thr_sel[1];
                rd_mux[CFG_SEL_LO_BIT] = cfg_r.thr_sel[0];
                rd_mux[CFG_POL_BIT] = cfg_r.pol_only;
            end
            EN_ADDR: rd_mux[EV_HI_BIT:EV_LO_BIT] = en_r;
            STAT_ADDR:
            begin
                rd_mux[EV_HI_BIT:EV_LO_BIT] = pend_r;
                rd_mux[STAT_ABSENT_BIT] = absent_r;
            end
            ALT_ADDR:
            begin
                rd_mux[ALT_EN_BIT] = alt_en_r;
                rd_mux[ALT_PEND_BIT] = alt_pend_r;
                rd_mux[ALT_STAT_BIT] = alt_on;
            end
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            rdata_r <= '0;
            data_r <= 1'b0;
        end
        else
        begin
            rdata_r <= REG_RD_I ? rd_mux : '0;
            data_r <= ev.data;
        end
    end

    assign REG_RDATA_O = rdata_r;
    assign DECODED_DATA_O = data_r;
    assign INTERRUPT_OUT_N_O = irq_n_r;

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    chk_irq_raise: // R1
    assert property ((pend_r & en_r) != 4'h0 |=> !INTERRUPT_OUT_N_O)
        else $error("enabled pending bit gave no interrupt");

    chk_irq_idle: // R2
    assert property ((en_r == 4'h0 && !alt_en_r) |=> INTERRUPT_OUT_N_O)
        else $error("interrupt raised with all enables clear");

    chk_strict_irq: // R11
    assert property ((alt_pend_r && alt_en_r) |=> !INTERRUPT_OUT_N_O)
        else $error("strict absence change gave no interrupt");

    chk_read_clear: // R3
    assert property (rd_stat |=> pend_r == $past(pend_set))
        else $error("status read left stale pending bits");

    chk_absent_pend: // R7
    assert property ($changed(absent_r) |-> pend_r[2])
        else $error("absence change did not set its pending bit");

    chk_absent_set: // R10
    assert property (space_run > thr |=> absent_r)
        else $error("long space run did not declare absence");

    chk_absent_mark: // R10
    assert property (ev.mark |=> !absent_r)
        else $error("mark did not clear absence");

    chk_alt_pend: // R12
    assert property ($changed(alt_on) |-> alt_pend_r)
        else $error("strict status change did not set pending");

    chk_alt_hold: // R13
    assert property ((alt_on && quiet_r < QUIET_PERIODS) |=> alt_on)
        else $error("strict absence cleared too early");

    chk_alt_release: // R13
    assert property ($fell(alt_on) |-> $past(quiet_r) == QUIET_PERIODS)
        else $error("strict absence cleared without quiet time");

endmodule

// ===== core/elcam_pkg.sv
// constants, field positions and carrier types of the line alarm monitor
// assumes one received line bit per system clock cycle
//
// Notes on behaviour
// R1: interrupt output asserts when an enabled indication reports an event.
// R2: reset clears the four interrupt enables, so no interrupt follows reset.
// R3: pending bits 7..4 latch events and all clear on a status read.
// R4: plain decoding flags a violation on two successive same-polarity marks.
// R5: strict mode flags a repeat-polarity violation or one lacking two spaces.
// R6: polarity-only option flags only two same-polarity successive violations.
// R7: signal-absent pending sets when the absence status changes either way.
// R8: signature pending sets on two spaces then opposite-polarity violation.
// R9: four-zero pending sets whenever four spaces arrive in a row.
// R10: absence status sets when space run exceeds threshold, clears on a mark.
// R11: strict-absence enable raises interrupt when strict status changes.
// R12: strict-absence pending sets on status change, clears on register read.
// R13: strict alarm sets over threshold, ends after 255 periods without 0000.
// R14: thresholds are 10 or 15 for select 00, then 31, 63 and 175.
// R15: plain select stops substitution; else signatures decode as four zeros.
// R16: interrupt is the OR of enabled pending bits, held until cleared.

package elcam_pkg;

    // ***************************************************************
    // register bus
    // ***************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] EN_ADDR = 8'h11;
    localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h12;
    localparam logic [ADDR_W-1:0] ALT_ADDR = 8'h13;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int CFG_PLAIN_BIT = 7;
    localparam int CFG_SEL_HI_BIT = 6;
    localparam int CFG_SEL_LO_BIT = 5;
    localparam int CFG_POL_BIT = 1;
    localparam int EV_HI_BIT = 7;
    localparam int EV_LO_BIT = 4;
    localparam int STAT_ABSENT_BIT = 0;
    localparam int ALT_EN_BIT = 7;
    localparam int ALT_PEND_BIT = 6;
    localparam int ALT_STAT_BIT = 0;

    // ***************************************************************
    // reset values and counts
    // ***************************************************************
    localparam logic [3:0] EN_RST = 4'h0;
    localparam logic [3:0] PEND_RST = 4'h0;
    localparam logic [7:0] RUN_RST = 8'h00;
    localparam logic [7:0] RUN_MAX = 8'hFF;
    localparam logic [7:0] THR_SUBST = 8'h0A;
    localparam logic [7:0] THR_PLAIN = 8'h0F;
    localparam logic [7:0] THR_SEL1 = 8'h1F;
    localparam logic [7:0] THR_SEL2 = 8'h3F;
    localparam logic [7:0] THR_SEL3 = 8'hAF;
    localparam logic [7:0] QUIET_PERIODS = 8'hFF;
    localparam logic [7:0] Z4_LEN = 8'h04;
    localparam logic [7:0] BPV_GAP = 8'h02;

    // ***************************************************************
    // types
    // ***************************************************************
    typedef struct packed {
        logic plain;
        logic pol_only;
        logic [1:0] thr_sel;
    } elcam_cfg_t;

    localparam elcam_cfg_t CFG_RST = '{plain: 1'b0, pol_only: 1'b0,
                                       thr_sel: 2'h0};

    typedef struct packed {
        logic viol;
        logic sig;
        logic z4;
        logic mark;
        logic data;
    } elcam_evt_t;

    typedef enum logic {
        ALT_CLEAR,
        ALT_DECLARED
    } elcam_alt_state_t;

endpackage

// ===== core/elcam_decode.sv
// bipolar line decoder: violations, signatures, space runs, substitution
// assumes synchronised rails, one bit period per clock cycle

module elcam_decode
    import elcam_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pos_i,
    input wire logic neg_i,
    input wire elcam_cfg_t cfg_i,
    output elcam_evt_t evt_o,
    output logic [7:0] space_run_o
);

    logic mark;
    logic pol;
    logic bpv;
    logic two_sp;
    logic same_bpv;
    logic viol;
    logic sig;
    logic have_mark_r;
    logic last_pol_r;
    logic have_bpv_r;
    logic bpv_pol_r;
    logic [7:0] run_r;
    logic [7:0] run_nxt;
    logic [3:0] sr_r;
    logic [3:0] sr_nxt;
    elcam_evt_t evt_r;

    // both rails high at once is taken as a positive mark
    assign mark = pos_i | neg_i;
    assign pol = pos_i;
    assign bpv = mark & have_mark_r & (pol == last_pol_r);
    assign two_sp = run_r >= BPV_GAP;
    assign same_bpv = have_bpv_r & (pol == bpv_pol_r);
    assign sig = bpv & two_sp & ~same_bpv; // R8
    assign run_nxt = mark ? RUN_RST :
                     (run_r == RUN_MAX) ? run_r : run_r + 8'h01;

    always_comb
    begin
        if (cfg_i.plain)
        begin
            viol = bpv; // R4
        end
        else if (cfg_i.pol_only)
        begin
            viol = bpv & same_bpv; // R6
        end
        else
        begin
            viol = bpv & (same_bpv | ~two_sp); // R5
        end
    end

    // a signature wipes itself and the three bits before it
    always_comb
    begin
        sr_nxt = {sr_r[2:0], mark};
        if (sig && !cfg_i.plain)
        begin
            sr_nxt = 4'h0; // R15
        end
    end

    // ***************************************************************
    // line history
    // ***************************************************************
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            have_mark_r <= 1'b0;
            last_pol_r <= 1'b0;
            have_bpv_r <= 1'b0;
            bpv_pol_r <= 1'b0;
        end
        else
        begin
            if (mark)
            begin
                have_mark_r <= 1'b1;
                last_pol_r <= pol;
            end
            if (bpv)
            begin
                have_bpv_r <= 1'b1;
                bpv_pol_r <= pol;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            run_r <= RUN_RST;
            sr_r <= 4'h0;
            evt_r <= '0;
        end
        else
        begin
            run_r <= run_nxt;
            sr_r <= sr_nxt;
            evt_r.viol <= viol;
            evt_r.sig <= sig;
            evt_r.z4 <= !mark && (run_nxt == Z4_LEN); // R9
            evt_r.mark <= mark;
            evt_r.data <= sr_nxt[3];
        end
    end

    assign evt_o = evt_r;
    assign space_run_o = run_r;

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_mark_then_four;
        mark ##1 (!pos_i && !neg_i) [*4];
    endsequence

    sequence s_two_pos_plain;
        (cfg_i.plain && pos_i && !neg_i) ##1 (cfg_i.plain && pos_i && !neg_i);
    endsequence

    chk_four_zero: // R9
    assert property (s_mark_then_four |=> evt_r.z4)
        else $error("four spaces gave no four-zero pulse");

    chk_plain_viol: // R4
    assert property (s_two_pos_plain |=> evt_r.viol)
        else $error("same polarity marks gave no violation");

endmodule

// ===== verification/elcam_line_model.sv
// line partner: turns symbol codes from the bench into rail levels
// assumes codes change just after the rising clock edge
module elcam_line_model
(
    input wire logic [1:0] sym_i,
    output logic pos_o,
    output logic neg_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // code 0 leaves both rails low: a space, never a stale mark
    assign pos_o = (sym_i == 2'h1);
    assign neg_o = (sym_i == 2'h2);
endmodule

// ===== verification/tb.sv
// bench: register port driver, line stimulus and read scoreboard
// assumes elcam_pkg, elcam_monitor and elcam_line_model compiled first
module tb
    import elcam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] sym = 2'h0;
    logic pos;
    logic neg;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic dec;
    logic int_n;
    logic last_pos = 1'b0;
    logic [7:0] exp_q[$];
    byte sym_q[$];
    byte c;
    int num_errors = 0;
    int checked = 0;
    int ones = 0;
    logic [7:0] ra;
    logic [7:0] thr[5] = '{THR_SUBST, THR_PLAIN, THR_SEL1, THR_SEL2, THR_SEL3};
    logic [7:0] tcfg[5] = '{8'h00, 8'h80, 8'h20, 8'h40, 8'h60};
    logic [7:0] ecfg[7] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02};
    logic [7:0] eexp[7] = '{8'h80, 8'h80, 8'h20, 8'h80, 8'h80, 8'h20, 8'h80};
    string eseq[7] = '{"+s", "+s", "+a00s", "+a00s", "+s", "+a00s+s", "+s"};

    always #50 sys_clk = ~sys_clk;

    elcam_line_model i_line
    (
        .sym_i(sym),
        .pos_o(pos),
        .neg_o(neg)
    );

    elcam_monitor i_dut
    (
        .SYS_CLK_I(sys_clk),
        .RESET_I(reset),
        .RX_POSITIVE_RAIL_I(pos),
        .RX_NEGATIVE_RAIL_I(neg),
        .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata),
        .REG_WR_I(wr),
        .REG_RD_I(rd),
        .REG_RDATA_O(rdata),
        .DECODED_DATA_O(dec),
        .INTERRUPT_OUT_N_O(int_n)
    );

    // ****************************************
    // comparison and closing
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     want);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ****************************************
    // register port and line stimulus
    // ****************************************
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
    endtask

    task automatic int_is(input logic want);
        @(posedge sys_clk);
        check({7'h00, int_n}, {7'h00, want});
    endtask

    task automatic spaces(input int n);
        repeat (n) sym_q.push_back("0");
    endtask

    // codes: 0 space, a alternate mark, s same-polarity mark, + see below
    task automatic play(input string s, input int settle);
        for (int i = 0; i < s.len(); i++)
            sym_q.push_back(s[i]);
        for (int i = 0; i < 4000 && sym_q.size() != 0; i++)
            @(posedge sys_clk);
        if (sym_q.size() != 0)
        begin
            num_errors++;
            give_verdict();
        end
        repeat (settle) @(posedge sys_clk);
    endtask

    // '+' sends alternating marks until one is positive, so a pattern
    // starts from a known polarity without ever forming a violation;
    // an empty queue sends alternating marks so the line never goes quiet
    always @(posedge sys_clk)
    begin
        c = (sym_q.size() != 0) ? sym_q[0] : "a";
        if (c != "0" && c != "s")
            last_pos = !last_pos;
        if (sym_q.size() != 0 && (c != "+" || last_pos))
            void'(sym_q.pop_front());
        sym <= (c == "0") ? 2'h0 : (last_pos ? 2'h1 : 2'h2);
    end

    always @(posedge sys_clk)
        if (dec === 1'b1)
            ones++;

    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk)
    begin
        rd_d <= rd;
        if (rd_d)
            check(rdata, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx);
    end

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        give_verdict();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h0000_b970));
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        int_is(1'b1);
        reg_read(EN_ADDR, 8'h00);
        reg_read(STAT_ADDR, 8'h00);
        reg_read(ALT_ADDR, 8'h00);
        reg_read(CFG_ADDR, 8'h00);
        repeat (4)
        begin
            ra = 8'h14 + 8'($urandom % 236);
            reg_write(ra, 8'($urandom));
            reg_read(ra, 8'h00);
        end
        reg_read(EN_ADDR, 8'h00);
        reg_write(EN_ADDR, 8'hF0);
        reg_read(EN_ADDR, 8'hF0);
        for (int i = 0; i < 7; i++)
        begin
            reg_write(CFG_ADDR, ecfg[i]);
            play(eseq[i], 8);
            int_is(eexp[i] == 8'h00);
            reg_read(STAT_ADDR, eexp[i]);
            repeat (3) @(posedge sys_clk);
            int_is(1'b1);
        end
        for (int m = 0; m < 2; m++)
        begin
            reg_write(CFG_ADDR, (m != 0) ? 8'hE0 : 8'h60);
            play("+000000000000", 0);
            ones = 0;
            play("a000s0000000000000000", 0);
            check(8'(ones), (m != 0) ? 8'h02 : 8'h01);
            reg_write(STAT_ADDR, 8'hF0);
            reg_read(STAT_ADDR, 8'h00);
        end
        for (int i = 0; i < 5; i++)
        begin
            reg_write(CFG_ADDR, tcfg[i]);
            spaces(thr[i]);
            play("a", 8);
            reg_read(STAT_ADDR, 8'h10);
            spaces(thr[i] + 21);
            repeat (thr[i] + 9) @(posedge sys_clk);
            reg_read(STAT_ADDR, 8'h51);
            play("a", 8);
            reg_read(STAT_ADDR, 8'h40);
        end
        // the quiet count restarts at the last run of zeros above
        reg_write(EN_ADDR, 8'h00);
        reg_write(ALT_ADDR, 8'hC0);
        reg_read(ALT_ADDR, 8'h81);
        int_is(1'b1);
        repeat (200) @(posedge sys_clk);
        reg_read(ALT_ADDR, 8'h81);
        repeat (60) @(posedge sys_clk);
        int_is(1'b0);
        reg_read(ALT_ADDR, 8'hC0);
        repeat (3) @(posedge sys_clk);
        int_is(1'b1);
        give_verdict();
    end
endmodule
